// >>> core/fbmc_top.sv
/*
  Control word of a fieldbus master: applies network state, redundancy role
  and per-node exchange enables from the host's output assembly, and
  reports node faults. Assumes the master engine and host byte feed run on
  this clock; configured/present vectors come from the engine.
*/
`timescale 1ns/100ps
`default_nettype none
// Function
// - command 0 puts network offline; command 1 puts it in stop.
// - command 2 drives network to clear; command 3 to operational.
// - role byte 0 means standby, 1 means active role.
// - one enable bit per node 0..126; set bit permits exchange if configured and the network is not offline.
// - cleared enable bit forbids exchange even with configured present node.
// - a missing node that is enabled and configured shows on node_missing and fault_led while the network is not offline.
// - per-node disabled flag is 1 whenever its enable bit is not set.
module fbmc_top #(
  parameter int NODES = fbmc_pkg::NODES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic asm_valid,
  input wire logic asm_sof,
  input wire logic [7:0] asm_byte,
  input wire logic [NODES-1:0] node_configured,
  input wire logic [NODES-1:0] node_present,
  output fbmc_pkg::fbmc_state_t net_state,
  output logic role_active,
  output logic [NODES-1:0] node_exchange_enable_mask,
  output logic [NODES-1:0] exchange_permit,
  output logic [NODES-1:0] node_disabled_flag,
  output logic [NODES-1:0] node_missing,
  output logic fault_led,
  output logic ctrl_error
);
  if (NODES < 1 || NODES > 8*fbmc_pkg::MASK_BYTES) begin : g_nodes_check
    $error("NODES must lie within the assembly's enable mask");
  end

  logic frame_done;
  logic [7:0] cmd_byte, role_byte;
  logic [8*fbmc_pkg::MASK_BYTES-1:0] mask_bits;

  fbmc_asm_rx u_rx (
    .clock(clock),
    .rst_n(rst_n),
    .asm_valid(asm_valid),
    .asm_sof(asm_sof),
    .asm_byte(asm_byte),
    .frame_done(frame_done),
    .cmd_byte(cmd_byte),
    .role_byte(role_byte),
    .mask_bits(mask_bits)
  );

  function automatic logic cmd_known(input logic [7:0] c);
    cmd_known = (c <= fbmc_pkg::CMD_OPER);
  endfunction : cmd_known

  function automatic logic role_known(input logic [7:0] r);
    role_known = (r == fbmc_pkg::ROLE_STANDBY) || (r == fbmc_pkg::ROLE_ACTIVE);
  endfunction : role_known

  fbmc_pkg::fbmc_state_t next_state;
  logic next_role, next_err, next_led;
  logic [NODES-1:0] next_mask, next_permit, next_dis, next_miss;
  logic link_up;

  // control: state, role, enable mask, latched at each complete assembly
  always_comb begin
    next_state = net_state;
    next_role = role_active;
    next_mask = node_exchange_enable_mask;
    next_err = ctrl_error;
    if (frame_done) begin
      next_mask = mask_bits[NODES-1:0];
      next_err = !cmd_known(cmd_byte) || !role_known(role_byte);
      // an unknown command or role keeps the old value and raises ctrl_error
      case (cmd_byte)
        fbmc_pkg::CMD_OFFLINE: next_state = fbmc_pkg::FBMC_OFFLINE;
        fbmc_pkg::CMD_STOP: next_state = fbmc_pkg::FBMC_STOP;
        fbmc_pkg::CMD_CLEAR: next_state = fbmc_pkg::FBMC_CLEAR;
        fbmc_pkg::CMD_OPER: next_state = fbmc_pkg::FBMC_OPER;
        default: next_state = net_state;
      endcase
      if (role_byte == fbmc_pkg::ROLE_STANDBY)
        next_role = 1'b0;
      else if (role_byte == fbmc_pkg::ROLE_ACTIVE)
        next_role = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      net_state <= fbmc_pkg::FBMC_OFFLINE;
      role_active <= 1'b0;
      node_exchange_enable_mask <= '0;
      ctrl_error <= 1'b0;
    end else begin
      net_state <= next_state;
      role_active <= next_role;
      node_exchange_enable_mask <= next_mask;
      ctrl_error <= next_err;
    end
  end

  // per-node exchange permission and fault view, from the next control values
  always_comb begin
    link_up = (next_state != fbmc_pkg::FBMC_OFFLINE);
    next_permit = next_mask & node_configured & {NODES{link_up}};
    next_dis = ~next_mask;
    next_miss = next_mask & node_configured & ~node_present & {NODES{link_up}};
    next_led = |next_miss;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      exchange_permit <= '0;
      node_disabled_flag <= '1;
      node_missing <= '0;
      fault_led <= 1'b0;
    end else begin
      exchange_permit <= next_permit;
      node_disabled_flag <= next_dis;
      node_missing <= next_miss;
      fault_led <= next_led;
    end
  end

  a_cmd_offline: assert property (@(posedge clock) disable iff (!rst_n)
    frame_done && cmd_byte == fbmc_pkg::CMD_OFFLINE |=> net_state == fbmc_pkg::FBMC_OFFLINE)
    else $error("command 0 did not take the network offline");
  a_cmd_stop: assert property (@(posedge clock) disable iff (!rst_n)
    frame_done && cmd_byte == fbmc_pkg::CMD_STOP |=> net_state == fbmc_pkg::FBMC_STOP)
    else $error("command 1 did not stop the network");
  a_cmd_clear: assert property (@(posedge clock) disable iff (!rst_n)
    frame_done && cmd_byte == fbmc_pkg::CMD_CLEAR |=> net_state == fbmc_pkg::FBMC_CLEAR)
    else $error("command 2 did not clear the network");
  a_cmd_oper: assert property (@(posedge clock) disable iff (!rst_n)
    frame_done && cmd_byte == fbmc_pkg::CMD_OPER |=> net_state == fbmc_pkg::FBMC_OPER)
    else $error("command 3 did not make the network operational");
  a_role_confirm: assert property (@(posedge clock) disable iff (!rst_n)
    frame_done && role_known(role_byte) |=> role_active == $past(role_byte[0]))
    else $error("role byte not applied");
  a_mask_load: assert property (@(posedge clock) disable iff (!rst_n)
    frame_done |=> node_exchange_enable_mask == $past(mask_bits[NODES-1:0]))
    else $error("enable mask not loaded from assembly");
  a_no_exch_off: assert property (@(posedge clock) disable iff (!rst_n)
    (exchange_permit & ~node_exchange_enable_mask) == '0)
    else $error("exchange permitted with a cleared enable bit");
  a_offline_quiet: assert property (@(posedge clock) disable iff (!rst_n)
    net_state == fbmc_pkg::FBMC_OFFLINE |-> exchange_permit == '0)
    else $error("exchange permitted while offline");
  a_disabled_flag: assert property (@(posedge clock) disable iff (!rst_n)
    node_disabled_flag == ~node_exchange_enable_mask)
    else $error("disabled flag disagrees with enable mask");
  a_fault_led: assert property (@(posedge clock) disable iff (!rst_n)
    fault_led == (node_missing != '0))
    else $error("fault LED disagrees with missing nodes");
  a_rsv_ignored: assert property (@(posedge clock) disable iff (!rst_n)
    frame_done |=> ctrl_error == !(cmd_known($past(cmd_byte)) && role_known($past(role_byte))))
    else $error("error flag depends on something other than command and role");

  // control values move only at a complete assembly, unknown codes keep the old value
  a_state_quiet: assert property (@(posedge clock) disable iff (!rst_n)
    !frame_done |=> $stable(net_state))
    else $error("network state moved without a complete assembly");
  a_bad_cmd_hold: assert property (@(posedge clock) disable iff (!rst_n)
    frame_done && !cmd_known(cmd_byte) |=> $stable(net_state))
    else $error("unknown command changed the network state");
  a_err_bad_cmd: assert property (@(posedge clock) disable iff (!rst_n)
    frame_done && !cmd_known(cmd_byte) |=> ctrl_error)
    else $error("unknown command did not raise the error flag");
  a_err_quiet: assert property (@(posedge clock) disable iff (!rst_n)
    !frame_done |=> $stable(ctrl_error))
    else $error("error flag moved without a complete assembly");
  a_role_quiet: assert property (@(posedge clock) disable iff (!rst_n)
    !frame_done |=> $stable(role_active))
    else $error("role moved without a complete assembly");
  a_bad_role_hold: assert property (@(posedge clock) disable iff (!rst_n)
    frame_done && !role_known(role_byte) |=> $stable(role_active))
    else $error("unknown role byte changed the role");
  a_err_bad_role: assert property (@(posedge clock) disable iff (!rst_n)
    frame_done && !role_known(role_byte) |=> ctrl_error)
    else $error("unknown role byte did not raise the error flag");
  a_role_standby: assert property (@(posedge clock) disable iff (!rst_n)
    frame_done && role_byte == fbmc_pkg::ROLE_STANDBY |=> !role_active)
    else $error("role byte 0 did not give standby");
  a_role_active: assert property (@(posedge clock) disable iff (!rst_n)
    frame_done && role_byte == fbmc_pkg::ROLE_ACTIVE |=> role_active)
    else $error("role byte 1 did not give the active role");
  a_mask_quiet: assert property (@(posedge clock) disable iff (!rst_n)
    !frame_done |=> $stable(node_exchange_enable_mask))
    else $error("enable mask moved without a complete assembly");

  // exchange permission follows mask and state in the same cycle, configuration with one cycle of lag
  a_permit_cfg: assert property (@(posedge clock) disable iff (!rst_n)
    (exchange_permit & ~$past(node_configured)) == '0)
    else $error("exchange permitted with an unconfigured node");
  a_permit_exact: assert property (@(posedge clock) disable iff (!rst_n)
    exchange_permit == (node_exchange_enable_mask & $past(node_configured)
      & {NODES{net_state != fbmc_pkg::FBMC_OFFLINE}}))
    else $error("exchange permission disagrees with mask, configuration and state");

  // fault view: only enabled, configured, absent nodes while the network is up
  a_miss_enabled: assert property (@(posedge clock) disable iff (!rst_n)
    (node_missing & ~node_exchange_enable_mask) == '0)
    else $error("missing flag raised for a node that is not enabled");
  a_miss_present: assert property (@(posedge clock) disable iff (!rst_n)
    (node_missing & $past(node_present)) == '0)
    else $error("missing flag raised for a node that is present");
  a_miss_cfg: assert property (@(posedge clock) disable iff (!rst_n)
    (node_missing & ~$past(node_configured)) == '0)
    else $error("missing flag raised for an unconfigured node");
  a_miss_offline: assert property (@(posedge clock) disable iff (!rst_n)
    net_state == fbmc_pkg::FBMC_OFFLINE |-> node_missing == '0)
    else $error("missing flag raised while offline");
  a_led_offline: assert property (@(posedge clock) disable iff (!rst_n)
    net_state == fbmc_pkg::FBMC_OFFLINE |-> !fault_led)
    else $error("fault LED lit while offline");
endmodule : fbmc_top
`default_nettype wire

// >>> core/fbmc_pkg.sv
/*
  Shared constants for the fieldbus master control word: assembly layout,
  command codes, role codes, node count and reset values.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fbmc_pkg;
  localparam int NODES = 127;
  localparam int MASK_BYTES = 16;
  localparam int FRAME_BYTES = 20;
  localparam int IDX_W = 5;
  localparam logic [4:0] IDX_CMD = 5'h00;
  localparam logic [4:0] IDX_ROLE = 5'h01;
  localparam logic [4:0] IDX_RSV_LO = 5'h02;
  localparam logic [4:0] IDX_RSV_HI = 5'h03;
  localparam logic [4:0] IDX_MASK0 = 5'h04;
  localparam logic [4:0] IDX_LAST = 5'h13;
  localparam logic [7:0] CMD_OFFLINE = 8'h00;
  localparam logic [7:0] CMD_STOP = 8'h01;
  localparam logic [7:0] CMD_CLEAR = 8'h02;
  localparam logic [7:0] CMD_OPER = 8'h03;
  localparam logic [7:0] ROLE_STANDBY = 8'h00;
  localparam logic [7:0] ROLE_ACTIVE = 8'h01;
  localparam logic [7:0] BYTE_RST = 8'h00;

  typedef enum logic [1:0] {
    FBMC_OFFLINE = 2'b00,
    FBMC_STOP = 2'b01,
    FBMC_CLEAR = 2'b10,
    FBMC_OPER = 2'b11
  } fbmc_state_t;
endpackage : fbmc_pkg

// >>> core/fbmc_asm_rx.sv
/*
  Byte-serial receiver for the cyclic output control assembly.
  Assumes bytes arrive from host-side logic on the same clock, one per
  asm_valid, with asm_sof on the first byte of each assembly.
*/
`timescale 1ns/100ps
`default_nettype none
module fbmc_asm_rx (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic asm_valid,
  input wire logic asm_sof,
  input wire logic [7:0] asm_byte,
  output logic frame_done,
  output logic [7:0] cmd_byte,
  output logic [7:0] role_byte,
  output logic [8*fbmc_pkg::MASK_BYTES-1:0] mask_bits
);
  logic [fbmc_pkg::IDX_W-1:0] idx, next_idx;
  logic in_frame, next_in_frame;
  logic next_done;
  logic [7:0] next_cmd, next_role;
  logic [8*fbmc_pkg::MASK_BYTES-1:0] next_mask;
  logic [fbmc_pkg::IDX_W-1:0] pos;
  logic take;

  always_comb begin
    pos = asm_sof ? fbmc_pkg::IDX_CMD : idx;
    take = asm_valid && (asm_sof || in_frame);
    next_idx = idx;
    next_in_frame = in_frame;
    next_done = 1'b0;
    next_cmd = cmd_byte;
    next_role = role_byte;
    next_mask = mask_bits;
    if (take) begin
      next_idx = pos + 5'h01;
      next_in_frame = (pos != fbmc_pkg::IDX_LAST);
      next_done = (pos == fbmc_pkg::IDX_LAST);
      case (pos)
        fbmc_pkg::IDX_CMD: next_cmd = asm_byte;
        fbmc_pkg::IDX_ROLE: next_role = asm_byte;
        fbmc_pkg::IDX_RSV_LO, fbmc_pkg::IDX_RSV_HI: ; // reserved word dropped
        default: next_mask[8*(pos-fbmc_pkg::IDX_MASK0) +: 8] = asm_byte;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      idx <= fbmc_pkg::IDX_CMD;
      in_frame <= 1'b0;
      frame_done <= 1'b0;
      cmd_byte <= fbmc_pkg::BYTE_RST;
      role_byte <= fbmc_pkg::BYTE_RST;
      mask_bits <= '0;
    end else begin
      idx <= next_idx;
      in_frame <= next_in_frame;
      frame_done <= next_done;
      cmd_byte <= next_cmd;
      role_byte <= next_role;
      mask_bits <= next_mask;
    end
  end

  a_rsv_dropped: assert property (@(posedge clock) disable iff (!rst_n)
    take && (pos == fbmc_pkg::IDX_RSV_LO || pos == fbmc_pkg::IDX_RSV_HI)
      |=> $stable(cmd_byte) && $stable(role_byte) && $stable(mask_bits))
    else $error("reserved byte altered the captured assembly");
endmodule : fbmc_asm_rx
`default_nettype wire

// >>> tb/fbmc_host_model.sv
/*
  Host-side model: sends one whole 20-byte output control assembly per go.
  Assumes the same clock as the control word block.
*/
`timescale 1ns/100ps
`default_nettype none
module fbmc_host_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [7:0] cmd,
  input wire logic [7:0] role,
  input wire logic [127:0] mask,
  output logic asm_valid,
  output logic asm_sof,
  output logic [7:0] asm_byte,
  output logic busy
);
  logic [4:0] idx;
  logic [7:0] sel;
  always_comb begin
    // state command first, role, zero reserved word, then enables
    if (idx == fbmc_pkg::IDX_CMD) sel = cmd;
    else if (idx == fbmc_pkg::IDX_ROLE) sel = role;
    else if (idx < fbmc_pkg::IDX_MASK0) sel = 8'h00;
    else sel = mask[{idx - fbmc_pkg::IDX_MASK0, 3'b000} +: 8];
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      idx <= 5'h00;
      busy <= 1'b0;
      asm_valid <= 1'b0;
      asm_sof <= 1'b0;
      asm_byte <= 8'h00;
    end else if (busy) begin
      asm_valid <= 1'b1;
      asm_sof <= (idx == fbmc_pkg::IDX_CMD);
      asm_byte <= sel;
      idx <= idx + 5'h01;
      busy <= (idx != fbmc_pkg::IDX_LAST);
    end else begin
      // released data line inverts the last byte on every edge
      asm_valid <= 1'b0;
      asm_sof <= 1'b0;
      asm_byte <= ~asm_byte;
      idx <= 5'h00;
      busy <= go;
    end
  end
endmodule : fbmc_host_model
`default_nettype wire

// >>> tb/fbmc_top_tb_top.sv
/*
  Self-checking bench for the control word block, fed by the host model.
  Assumes one 200 MHz clock and an active-low asynchronous reset.
*/
`timescale 1ns/100ps
`default_nettype none
module fbmc_top_tb_top;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  logic [7:0] cmd = 8'h00;
  logic [7:0] role = 8'h00;
  logic [127:0] mask = 128'h0;
  logic [126:0] node_configured = 127'h0;
  logic [126:0] node_present = 127'h0;
  logic asm_valid, asm_sof, busy, role_active, fault_led, ctrl_error;
  logic [7:0] asm_byte;
  fbmc_pkg::fbmc_state_t net_state;
  logic [126:0] en_mask, permit, dis_flag, missing;
  int n_mismatch = 0;
  int checked = 0;
  always #2.5 clock = ~clock;
  fbmc_host_model i_fbmc_host_model (.clock(clock), .rst_n(rst_n), .go(go), .cmd(cmd),
    .role(role), .mask(mask), .asm_valid(asm_valid), .asm_sof(asm_sof),
    .asm_byte(asm_byte), .busy(busy));
  fbmc_top #(.NODES(127)) i_fbmc_top (.clock(clock), .rst_n(rst_n), .asm_valid(asm_valid),
    .asm_sof(asm_sof), .asm_byte(asm_byte), .node_configured(node_configured),
    .node_present(node_present), .net_state(net_state), .role_active(role_active),
    .node_exchange_enable_mask(en_mask), .exchange_permit(permit),
    .node_disabled_flag(dis_flag), .node_missing(missing), .fault_led(fault_led),
    .ctrl_error(ctrl_error));
  task automatic cmp(input logic [127:0] got, input logic [127:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic send(input logic [7:0] c, input logic [7:0] r, input logic [127:0] m);
    int n;
    n = 0;
    @(posedge clock);
    cmd <= c;
    role <= r;
    mask <= m;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (busy === 1'b1 && n < 100);
    if (n >= 100) n_mismatch++;
    // last byte taken next edge, results two edges later
    repeat (3) @(posedge clock);
    #1;
  endtask : send
  task automatic t_states();
    for (int c = 0; c < 4; c++) begin
      send(8'(c), 8'(c % 2), 128'h0);
      cmp(128'(net_state), 128'(c));
      cmp(128'(role_active), 128'(c % 2));
      cmp(128'(ctrl_error), 128'h0);
    end
    $display("test states done");
  endtask : t_states
  task automatic t_mask();
    @(posedge clock);
    node_configured <= 127'h1 | (127'h1 << 5) | (127'h1 << 126);
    node_present <= 127'h1 | (127'h1 << 5);
    send(8'h03, 8'h01, 128'h5 | (128'h3 << 126));
    cmp(128'(en_mask), 128'h5 | (128'h1 << 126));
    cmp(128'(permit), 128'h1 | (128'h1 << 126));
    cmp(128'(dis_flag), {1'b0, ~(127'h5 | (127'h1 << 126))});
    cmp(128'(missing), 128'h1 << 126);
    cmp(128'(fault_led), 128'h1);
    $display("test mask done");
  endtask : t_mask
  task automatic t_bad();
    send(8'h05, 8'h02, 128'h0);
    cmp(128'(net_state), 128'h3);
    cmp(128'(role_active), 128'h1);
    cmp(128'(ctrl_error), 128'h1);
    $display("test bad codes done");
  endtask : t_bad
  task automatic t_offline();
    send(8'h00, 8'h00, 128'h21);
    cmp(128'(net_state), 128'h0);
    cmp(128'(role_active), 128'h0);
    cmp(128'(ctrl_error), 128'h0);
    cmp(128'(en_mask), 128'h21);
    cmp(128'(permit), 128'h0);
    cmp(128'(dis_flag), {1'b0, ~127'h21});
    cmp(128'(missing), 128'h0);
    cmp(128'(fault_led), 128'h0);
    send(8'h01, 8'h00, 128'h21);
    cmp(128'(net_state), 128'h1);
    cmp(128'(permit), 128'h21);
    cmp(128'(missing), 128'h0);
    $display("test offline and stop done");
  endtask : t_offline
  task automatic t_reset();
    // reset low through seven rising edges, released on an edge
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (7) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    cmp(128'(net_state), 128'h0);
    cmp(128'(role_active), 128'h0);
    cmp(128'(en_mask), 128'h0);
    cmp(128'(dis_flag), {1'b0, {127{1'b1}}});
    $display("test reset done");
  endtask : t_reset
  task automatic complete_run();
    $display("compares %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  initial begin
    t_reset();
    t_states();
    t_mask();
    t_bad();
    t_offline();
    t_reset();
    t_states();
    complete_run();
  end
  initial begin
    repeat (3000) @(posedge clock);
    n_mismatch++;
    complete_run();
  end
endmodule : fbmc_top_tb_top
`default_nettype wire
